// ==== core/pmc_pointer_mask_config.sv ====
`timescale 1ns/100ps
`include "pmc_defines.svh"

// Summary of operation
// - Mask-mode fields are 2 bits; illegal writes keep the old legal value.
// - Decode 00 none, 01 reserved, 10 seven bits, 11 sixteen bits.
// - On a 32-bit hart all mask-mode fields read zero and ignore writes.
// - Masking is active only on a 64-bit hart; enabling otherwise is refused.
// - A mode whose register width is 32 refuses mask enables.
// - Setting a mode's width to 32 clears its field; no later restore.
// - Supervisor config bits 33:32 govern user and virtual-user masking.
// - Hypervisor config bits 33:32 govern virtual-supervisor masking.
// - Hypervisor status bits 49:48 govern user-issued virtual-user hyp accesses.
// - Hyp accesses from supervisor or machine as virtual-user use supervisor field.
// - Hyp accesses as virtual-supervisor use the hypervisor config field.
// - Execute-permission hyp loads are never masked.
// - Make-executable-readable at the effective mode disables masking.
// - Machine config bits 33:32 govern supervisor, or user without supervisor.
// - Virtual modes with bare guest translation use zero-extending masking.
// - Machine security config bits 33:32 govern machine-mode masking.
// - Machine-mode masking support implies the security config register exists.
// - Masking touches only effective addresses; mode changes need no fence.
// - The active mode's setting applies; it lives in the next-higher mode's register, except machine's, which is in its security config.
// - Modify-privilege and virtual-privilege controls select the effective mode's setting.
module pmc_pointer_mask_config #(
  parameter bit RV64       = 1'b1,
  parameter bit HAS_SUPER  = 1'b1,
  parameter bit HAS_HYP    = 1'b1,
  parameter bit HAS_MACH   = 1'b1
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                resetn,
  // Field writes
  input  wire logic                seccfg_write,
  input  wire logic                menvcfg_write,
  input  wire logic                senvcfg_write,
  input  wire logic                henvcfg_write,
  input  wire logic                hstatus_write,
  input  wire pmc_pkg::pmc_mode_t  write_mode,
  // Register width per mode
  input  wire logic                mach_width_32,
  input  wire logic                super_width_32,
  input  wire logic                user_width_32,
  input  wire logic                vsuper_width_32,
  input  wire logic                vuser_width_32,
  input  wire logic                mach_width_set,
  input  wire logic                super_width_set,
  input  wire logic                user_width_set,
  input  wire logic                vsuper_width_set,
  input  wire logic                vuser_width_set,
  // Explicit access request
  input  wire logic                access_valid,
  input  wire pmc_pkg::pmc_priv_t  priv,
  input  wire logic                virt,
  input  wire logic                hyp_virtual_load,
  input  wire logic                hyp_virtual_store,
  input  wire logic                hyp_exec_perm_load,
  input  wire logic                modify_privilege,
  input  wire pmc_pkg::pmc_priv_t  prev_priv,
  input  wire logic                prev_virt,
  input  wire logic                sup_virtual_privilege,
  input  wire logic                make_executable_readable,
  input  wire logic                vs_make_executable_readable,
  input  wire logic                satp_bare,
  input  wire logic                vsatp_bare,
  // Resolved masking
  output logic                     result_valid,
  output logic [4:0]               masked_bit_count,
  output logic                     zero_extend,
  // Configuration images
  output logic [63:0]              seccfg_image,
  output logic [63:0]              menvcfg_image,
  output logic [63:0]              senvcfg_image,
  output logic [63:0]              henvcfg_image,
  output logic [63:0]              hstatus_image,
  output logic                     seccfg_present
);

  pmc_pkg::pmc_mode_t mode_mach;
  pmc_pkg::pmc_mode_t mode_menv;
  pmc_pkg::pmc_mode_t mode_senv;
  pmc_pkg::pmc_mode_t mode_henv;
  pmc_pkg::pmc_mode_t hyp_user_mask_mode;
  logic               menv_width_32;
  logic               menv_width_set;

  // Machine config governs user directly when supervisor is absent
  assign menv_width_32  = HAS_SUPER ? super_width_32 : user_width_32;
  assign menv_width_set = HAS_SUPER ? super_width_set : user_width_set;

  pmc_mode_field #(.ENABLED(RV64 && HAS_MACH)) u_seccfg (
    .clock       (clock),
    .resetn      (resetn),
    .write_en    (seccfg_write),
    .write_data  (write_mode),
    .width_is_32 (mach_width_32),
    .width_set   (mach_width_set),
    .field_value (mode_mach)
  );

  pmc_mode_field #(.ENABLED(RV64)) u_menvcfg (
    .clock       (clock),
    .resetn      (resetn),
    .write_en    (menvcfg_write),
    .write_data  (write_mode),
    .width_is_32 (menv_width_32),
    .width_set   (menv_width_set),
    .field_value (mode_menv)
  );

  pmc_mode_field #(.ENABLED(RV64 && HAS_SUPER)) u_senvcfg (
    .clock       (clock),
    .resetn      (resetn),
    .write_en    (senvcfg_write),
    .write_data  (write_mode),
    .width_is_32 (user_width_32),
    .width_set   (user_width_set),
    .field_value (mode_senv)
  );

  pmc_mode_field #(.ENABLED(RV64 && HAS_HYP)) u_henvcfg (
    .clock       (clock),
    .resetn      (resetn),
    .write_en    (henvcfg_write),
    .write_data  (write_mode),
    .width_is_32 (vsuper_width_32),
    .width_set   (vsuper_width_set),
    .field_value (mode_henv)
  );

  pmc_mode_field #(.ENABLED(RV64 && HAS_HYP)) u_hstatus (
    .clock       (clock),
    .resetn      (resetn),
    .write_en    (hstatus_write),
    .write_data  (write_mode),
    .width_is_32 (vuser_width_32),
    .width_set   (vuser_width_set),
    .field_value (hyp_user_mask_mode)
  );

  function automatic logic [63:0] place(input pmc_pkg::pmc_mode_t value, input int lsb);
    logic [63:0] image;
    image = 64'h0000_0000_0000_0000;
    image[lsb +: 2] = value;
    return image;
  endfunction : place

  function automatic logic [4:0] decode(input pmc_pkg::pmc_mode_t value);
    logic [4:0] count;
    count = `PMC_LEN_NONE;
    case (value)
      `PMC_MODE_LEN7:  count = `PMC_LEN_SHORT;
      `PMC_MODE_LEN16: count = `PMC_LEN_LONG;
      default:         count = `PMC_LEN_NONE;
    endcase
    return count;
  endfunction : decode

  assign seccfg_image   = place(mode_mach, `PMC_FIELD_LSB);
  assign menvcfg_image  = place(mode_menv, `PMC_FIELD_LSB);
  assign senvcfg_image  = place(mode_senv, `PMC_FIELD_LSB);
  assign henvcfg_image  = place(mode_henv, `PMC_FIELD_LSB);
  assign hstatus_image  = place(hyp_user_mask_mode, `PMC_HYP_USER_MASK_MODE_LSB);
  assign seccfg_present = HAS_MACH;

  // Effective mode and field selection
  pmc_pkg::pmc_priv_t eff_priv;
  logic               eff_virt;
  logic               hyp_access;
  pmc_pkg::pmc_mode_t sel_mode;
  logic               next_result_valid;
  logic [4:0]         next_masked_bit_count;
  logic               next_zero_extend;

  assign hyp_access = hyp_virtual_load || hyp_virtual_store || hyp_exec_perm_load;

  always_comb begin
    eff_priv = priv;
    eff_virt = virt;
    if (hyp_access) begin
      eff_virt = 1'b1;
      eff_priv = sup_virtual_privilege ? pmc_pkg::priv_super : pmc_pkg::priv_user;
    end else if (modify_privilege && priv == pmc_pkg::priv_machine) begin
      eff_priv = prev_priv;
      eff_virt = prev_virt && prev_priv != pmc_pkg::priv_machine;
    end
  end

  // Each mode's setting sits with the next-higher mode, except machine's, which sits in its own security config
  always_comb begin
    sel_mode = `PMC_MODE_OFF;
    case (eff_priv)
      pmc_pkg::priv_machine: sel_mode = mode_mach;
      pmc_pkg::priv_super:   sel_mode = eff_virt ? mode_henv : mode_menv;
      pmc_pkg::priv_user: begin
        if (!eff_virt) begin
          sel_mode = HAS_SUPER ? mode_senv : mode_menv;
        end else if (hyp_access && priv == pmc_pkg::priv_user) begin
          sel_mode = hyp_user_mask_mode;
        end else begin
          sel_mode = mode_senv;
        end
      end
      default: sel_mode = `PMC_MODE_OFF;
    endcase
  end

  // Resolution uses current fields only, so no fence state is kept
  always_comb begin
    next_result_valid     = access_valid;
    next_masked_bit_count = decode(sel_mode);
    next_zero_extend      = eff_virt ? vsatp_bare
                                     : (eff_priv == pmc_pkg::priv_machine || satp_bare);
    if (hyp_exec_perm_load) begin
      next_masked_bit_count = `PMC_LEN_NONE;
    end
    if (make_executable_readable || (eff_virt && vs_make_executable_readable)) begin
      next_masked_bit_count = `PMC_LEN_NONE;
    end
    if (!RV64 || !access_valid) begin
      next_masked_bit_count = `PMC_LEN_NONE;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      result_valid     <= 1'b0;
      masked_bit_count <= `PMC_LEN_NONE;
      zero_extend      <= 1'b0;
    end else begin
      result_valid     <= next_result_valid;
      masked_bit_count <= next_masked_bit_count;
      zero_extend      <= next_zero_extend;
    end
  end

  sequence s_plain_req;
    access_valid && !hyp_access && !make_executable_readable && !vs_make_executable_readable;
  endsequence

  sequence s_hyp_req;
    access_valid && (hyp_virtual_load || hyp_virtual_store) && !hyp_exec_perm_load
      && !make_executable_readable && !vs_make_executable_readable && !sup_virtual_privilege;
  endsequence

  a_len_legal: assert property (@(posedge clock) disable iff (!resetn)
    result_valid |-> masked_bit_count inside {`PMC_LEN_NONE, `PMC_LEN_SHORT, `PMC_LEN_LONG})
    else $error("illegal masked bit count");

  a_exec_load_clear: assert property (@(posedge clock) disable iff (!resetn)
    access_valid && hyp_exec_perm_load |=> result_valid && masked_bit_count == `PMC_LEN_NONE)
    else $error("execute-permission hyp load masked");

  a_mxr_clear: assert property (@(posedge clock) disable iff (!resetn)
    access_valid && make_executable_readable |=> masked_bit_count == `PMC_LEN_NONE)
    else $error("masking applied under make-executable-readable");

  a_hyp_user_sel: assert property (@(posedge clock) disable iff (!resetn)
    s_hyp_req and (priv == pmc_pkg::priv_user && !virt)
      |=> masked_bit_count == decode($past(hyp_user_mask_mode)))
    else $error("user hyp access ignored hyp user mask mode");

  a_hyp_super_sel: assert property (@(posedge clock) disable iff (!resetn)
    s_hyp_req and (priv != pmc_pkg::priv_user && !virt)
      |=> masked_bit_count == decode($past(mode_senv)))
    else $error("privileged hyp access ignored supervisor field");

  a_mach_sel: assert property (@(posedge clock) disable iff (!resetn)
    s_plain_req and (priv == pmc_pkg::priv_machine && !modify_privilege)
      |=> masked_bit_count == decode($past(mode_mach)))
    else $error("machine access ignored security config field");

  a_vs_sel: assert property (@(posedge clock) disable iff (!resetn)
    s_plain_req and (priv == pmc_pkg::priv_super && virt)
      |=> masked_bit_count == decode($past(mode_henv)))
    else $error("virtual-supervisor access ignored hypervisor field");

  a_modify_privilege_sel: assert property (@(posedge clock) disable iff (!resetn)
    s_plain_req and (priv == pmc_pkg::priv_machine && modify_privilege
      && prev_priv == pmc_pkg::priv_super && !prev_virt)
      |=> masked_bit_count == decode($past(mode_menv)))
    else $error("modify-privilege access used wrong field");

  a_bare_zext: assert property (@(posedge clock) disable iff (!resetn)
    access_valid && !hyp_access && !modify_privilege && virt && vsatp_bare |=> zero_extend)
    else $error("bare guest translation not zero-extended");

  a_narrow_zero: assert property (@(posedge clock) disable iff (!resetn)
    !RV64 |-> masked_bit_count == `PMC_LEN_NONE && senvcfg_image == 64'h0000_0000_0000_0000)
    else $error("masking active on narrow hart");

endmodule : pmc_pointer_mask_config

// ==== shared/pmc_defines.svh ====
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// Mask-mode field encodings
`define PMC_MODE_OFF    2'h0
`define PMC_MODE_RSVD   2'h1
`define PMC_MODE_LEN7   2'h2
`define PMC_MODE_LEN16  2'h3
`define PMC_MODE_RESET  2'h0

// Resolved masked bit counts
`define PMC_LEN_NONE    5'h00
`define PMC_LEN_SHORT   5'h07
`define PMC_LEN_LONG    5'h10

// Field positions inside the 64-bit configuration images
`define PMC_FIELD_LSB   32
`define PMC_HYP_USER_MASK_MODE_LSB   48

`endif

// ==== shared/pmc_pkg.sv ====
package pmc_pkg;

  typedef enum logic [1:0] {
    priv_user,
    priv_super,
    priv_machine
  } pmc_priv_t;

  typedef logic [1:0] pmc_mode_t;

endpackage : pmc_pkg

// ==== core/pmc_mode_field.sv ====
`timescale 1ns/100ps
`include "pmc_defines.svh"

module pmc_mode_field #(
  parameter bit ENABLED = 1'b1
) (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            resetn,
  // Software write
  input  wire logic            write_en,
  input  wire pmc_pkg::pmc_mode_t write_data,
  // Register width of the governed mode
  input  wire logic            width_is_32,
  input  wire logic            width_set,
  // Stored value
  output pmc_pkg::pmc_mode_t   field_value
);

  pmc_pkg::pmc_mode_t next_field_value;

  always_comb begin
    next_field_value = field_value;
    if (!ENABLED) begin
      next_field_value = `PMC_MODE_OFF;
    end else if (width_set) begin
      next_field_value = `PMC_MODE_OFF;
    end else if (write_en && !width_is_32 && write_data != `PMC_MODE_RSVD) begin
      next_field_value = write_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      field_value <= `PMC_MODE_RESET;
    end else begin
      field_value <= next_field_value;
    end
  end

  a_width_clears: assert property (@(posedge clock) disable iff (!resetn)
    width_set |=> field_value == `PMC_MODE_OFF)
    else $error("mask mode not cleared by width write");

  a_reserved_kept: assert property (@(posedge clock) disable iff (!resetn)
    write_en && write_data == `PMC_MODE_RSVD && !width_set |=> $stable(field_value))
    else $error("reserved mask mode stored");

  a_narrow_refused: assert property (@(posedge clock) disable iff (!resetn)
    write_en && width_is_32 && !width_set |=> $stable(field_value))
    else $error("mask mode changed while mode is narrow");

endmodule : pmc_mode_field

// ==== testbench/pmc_testbench.sv ====
`timescale 1ns/100ps
`include "pmc_defines.svh"

module testbench;
  logic                clock = 1'b0;
  logic                resetn = 1'b0;
  logic [0:4]          wr = 5'h0;
  logic [0:4]          w32 = 5'h0;
  logic [0:4]          wset = 5'h0;
  logic [8:0]          af = 9'h000;
  pmc_pkg::pmc_mode_t  write_mode = 2'h0;
  pmc_pkg::pmc_priv_t  priv = pmc_pkg::priv_machine;
  pmc_pkg::pmc_priv_t  prev_priv = pmc_pkg::priv_machine;
  logic                access_valid = 1'b0;
  logic                satp_bare = 1'b0;
  logic                vsatp_bare = 1'b1;
  logic                seccfg_write, menvcfg_write, senvcfg_write, henvcfg_write, hstatus_write;
  logic                mach_width_32, super_width_32, user_width_32;
  logic                vsuper_width_32, vuser_width_32;
  logic                mach_width_set, super_width_set, user_width_set;
  logic                vsuper_width_set, vuser_width_set;
  logic                virt, hyp_virtual_load, hyp_virtual_store, hyp_exec_perm_load;
  logic                modify_privilege, prev_virt, sup_virtual_privilege;
  logic                make_executable_readable, vs_make_executable_readable;
  logic                result_valid, zero_extend, seccfg_present;
  logic [4:0]          masked_bit_count;
  logic [63:0]         seccfg_image, menvcfg_image, senvcfg_image, henvcfg_image, hstatus_image;
  logic                r32_valid, r32_ze;
  logic [4:0]          r32_cnt;
  logic [63:0]         r32_sec, r32_men, r32_sen, r32_hen, r32_hst;
  logic [1:0]          cfg [5] = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h0};
  int                  n_fail = 0;
  int                  compares = 0;
  int                  cycles = 0;

  // Field order everywhere: machine, super, user, virtual super, virtual user
  assign {seccfg_write, menvcfg_write, senvcfg_write, henvcfg_write, hstatus_write} = wr;
  assign {mach_width_32, super_width_32, user_width_32, vsuper_width_32, vuser_width_32} = w32;
  assign {mach_width_set, super_width_set, user_width_set, vsuper_width_set,
          vuser_width_set} = wset;
  assign {virt, hyp_virtual_load, hyp_virtual_store, hyp_exec_perm_load, modify_privilege,
          prev_virt, sup_virtual_privilege, make_executable_readable,
          vs_make_executable_readable} = af;

  pmc_pointer_mask_config uut (.*);

  // Narrow hart sharing every input
  pmc_pointer_mask_config #(.RV64(1'b0)) uut2 (
    .*,
    .result_valid     (r32_valid),
    .masked_bit_count (r32_cnt),
    .zero_extend      (r32_ze),
    .seccfg_image     (r32_sec),
    .menvcfg_image    (r32_men),
    .senvcfg_image    (r32_sen),
    .henvcfg_image    (r32_hen),
    .hstatus_image    (r32_hst),
    .seccfg_present   ()
  );

  always #50 clock = ~clock;

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [63:0] img(input int i);
    case (i)
      0: img = seccfg_image;
      1: img = menvcfg_image;
      2: img = senvcfg_image;
      3: img = henvcfg_image;
      default: img = hstatus_image;
    endcase
  endfunction : img

  function automatic logic [63:0] exp_img(input int i, input logic [1:0] f);
    exp_img = (i == 4) ? {14'h0, f, 48'h0} : {30'h0, f, 32'h0};
  endfunction : exp_img

  task automatic wr_fld(input int i, input logic [1:0] m, input logic [1:0] ef);
    @(posedge clock);
    wr[i] <= 1'b1;
    write_mode <= m;
    @(posedge clock);
    wr <= 5'h0;
    #1;
    chk(img(i), exp_img(i, ef));
  endtask : wr_fld

  task automatic acc(input pmc_pkg::pmc_priv_t p, input pmc_pkg::pmc_priv_t pp,
                     input logic [8:0] f, input logic [4:0] ec, input logic ez);
    @(posedge clock);
    priv <= p;
    prev_priv <= pp;
    af <= f;
    access_valid <= 1'b1;
    @(posedge clock);
    access_valid <= 1'b0;
    #1;
    chk(result_valid, 1'b1);
    chk(masked_bit_count, ec);
    chk(zero_extend, ez);
    chk(r32_cnt, `PMC_LEN_NONE);
    chk(r32_valid, 1'b1);
    chk(r32_ze, ez);
    @(posedge clock);
    #1;
    chk(result_valid, 1'b0);
  endtask : acc

  task automatic end_of_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    #1;
    for (int i = 0; i < 5; i++) chk(img(i), 64'h0);
    chk(result_valid, 1'b0);
    chk(seccfg_present, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr_fld(i, 2'h3, 2'h3);
      wr_fld(i, 2'h1, 2'h3);
      wr_fld(i, 2'h2, 2'h2);
    end
    chk(r32_sec | r32_men | r32_sen | r32_hen | r32_hst, 64'h0);
    $display("test fields done");
    for (int m = 0; m < 4; m++) begin
      wr_fld(2, m[1:0], (m == 1) ? 2'h0 : m[1:0]);
      acc(pmc_pkg::priv_user, pmc_pkg::priv_user, 9'h000, (m == 3) ? `PMC_LEN_LONG :
          (m == 2) ? `PMC_LEN_SHORT : `PMC_LEN_NONE, 1'b0);
    end
    $display("test decode done");
    for (int i = 0; i < 5; i++) wr_fld(i, cfg[i], cfg[i]);
    acc(pmc_pkg::priv_machine, pmc_pkg::priv_user, 9'h000, `PMC_LEN_LONG, 1'b1);
    acc(pmc_pkg::priv_super, pmc_pkg::priv_user, 9'h000, `PMC_LEN_SHORT, 1'b0);
    acc(pmc_pkg::priv_user, pmc_pkg::priv_user, 9'h000, `PMC_LEN_LONG, 1'b0);
    acc(pmc_pkg::priv_user, pmc_pkg::priv_user, 9'h100, `PMC_LEN_LONG, 1'b1);
    acc(pmc_pkg::priv_super, pmc_pkg::priv_user, 9'h100, `PMC_LEN_SHORT, 1'b1);
    acc(pmc_pkg::priv_user, pmc_pkg::priv_user, 9'h080, `PMC_LEN_NONE, 1'b1);
    acc(pmc_pkg::priv_super, pmc_pkg::priv_user, 9'h040, `PMC_LEN_LONG, 1'b1);
    acc(pmc_pkg::priv_machine, pmc_pkg::priv_user, 9'h080, `PMC_LEN_LONG, 1'b1);
    acc(pmc_pkg::priv_machine, pmc_pkg::priv_user, 9'h084, `PMC_LEN_SHORT, 1'b1);
    acc(pmc_pkg::priv_super, pmc_pkg::priv_user, 9'h044, `PMC_LEN_SHORT, 1'b1);
    acc(pmc_pkg::priv_super, pmc_pkg::priv_user, 9'h020, `PMC_LEN_NONE, 1'b1);
    acc(pmc_pkg::priv_user, pmc_pkg::priv_user, 9'h002, `PMC_LEN_NONE, 1'b0);
    acc(pmc_pkg::priv_user, pmc_pkg::priv_user, 9'h001, `PMC_LEN_LONG, 1'b0);
    acc(pmc_pkg::priv_user, pmc_pkg::priv_user, 9'h101, `PMC_LEN_NONE, 1'b1);
    acc(pmc_pkg::priv_machine, pmc_pkg::priv_super, 9'h010, `PMC_LEN_SHORT, 1'b0);
    acc(pmc_pkg::priv_machine, pmc_pkg::priv_user, 9'h018, `PMC_LEN_LONG, 1'b1);
    @(posedge clock);
    satp_bare <= 1'b1;
    acc(pmc_pkg::priv_super, pmc_pkg::priv_user, 9'h000, `PMC_LEN_SHORT, 1'b1);
    wr_fld(1, 2'h3, 2'h3);
    acc(pmc_pkg::priv_super, pmc_pkg::priv_user, 9'h000, `PMC_LEN_LONG, 1'b1);
    $display("test select done");
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      w32[i] <= 1'b1;
      wr_fld(i, (i == 3) ? 2'h3 : 2'h2, (i == 1) ? 2'h3 : cfg[i]);
      @(posedge clock);
      wset[i] <= 1'b1;
      @(posedge clock);
      wset <= 5'h0;
      w32 <= 5'h0;
      #1;
      chk(img(i), 64'h0);
      @(posedge clock);
      #1;
      chk(img(i), 64'h0);
      wr_fld(i, 2'h3, 2'h3);
    end
    @(posedge clock);
    wr[2] <= 1'b1;
    wset[2] <= 1'b1;
    write_mode <= 2'h2;
    @(posedge clock);
    wr <= 5'h0;
    wset <= 5'h0;
    #1;
    chk(senvcfg_image, 64'h0);
    $display("test width done");
    end_of_test();
  end
endmodule : testbench
